//--- hw/acf_ctrl.sv
// converter setup, main clock, reference and front-end sequencing control
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module acf_ctrl
  import acf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata,
  input  wire logic        standby,
  input  wire logic        clk_pin_i,
  output logic             clk_pin_o,
  output logic             clk_pin_oe,
  output logic             mclk_tick,
  output logic             mod_tick,
  output logic             conv_done,
  output logic             data_ready,
  output acf_fe_t          fe,
  output acf_ref_t         ref_ctl
);

  typedef enum logic [2:0] {
    ACF_ST_IDLE   = 3'b001,
    ACF_ST_SETTLE = 3'b010,
    ACF_ST_CONV   = 3'b100
  } acf_state_t;

  function automatic logic [19:0] conv_period(input acf_filt_t f);
    logic [19:0] fs;
    fs = (f.rate_divider == 11'h000) ? 20'd1 : {9'd0, f.rate_divider};
    case (f.ftype)
      ACF_F_SINC4_AVG: conv_period = fs * ACF_SINC4_AVG;
      ACF_F_SINC3_AVG: conv_period = fs * ACF_SINC3_AVG;
      ACF_F_SINC3_PF:
      begin
        case (f.post_sel)
          2'h0:    conv_period = ACF_POST_P0;
          2'h1:    conv_period = ACF_POST_P1;
          2'h2:    conv_period = ACF_POST_P2;
          default: conv_period = ACF_POST_P3;
        endcase
      end
      default:         conv_period = fs * ACF_TICKS_PER_FS;
    endcase
  endfunction : conv_period

  function automatic logic [3:0] next_chan(input logic [3:0]  cur,
                                           input logic [15:0] en);
    logic [3:0] idx;
    logic [3:0] pick;
    logic       found;
    pick  = cur;
    found = 1'b0;
    for (int i = 1; i <= 16; i++)
    begin
      idx = cur + 4'(i);
      if (!found && en[idx])
      begin
        pick  = idx;
        found = 1'b1;
      end
    end
    next_chan = pick;
  endfunction : next_chan

  // register file
  logic [5:0]  ctrl_r;
  logic [2:0]  misc_r;
  logic [15:0] bias_r;
  acf_chan_t   chan_r [ACF_NUM_CHAN];
  acf_cfg_t    cfg_r  [ACF_NUM_SETUP];
  acf_filt_t   filt_r [ACF_NUM_SETUP];
  logic [31:0] rdata_r;
  logic [31:0] rd_nxt;

  logic wr_chan;
  logic wr_cfg;
  logic wr_filt;
  logic rd_status;

  assign wr_chan   = reg_we && (reg_addr[7:4] == ACF_ADDR_CHAN[7:4]);
  assign wr_cfg    = reg_we && (reg_addr[7:3] == ACF_ADDR_CFG[7:3]);
  assign wr_filt   = reg_we && (reg_addr[7:3] == ACF_ADDR_FILT[7:3]);
  assign rd_status = reg_re && (reg_addr == ACF_ADDR_STATUS);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_r <= ACF_CTRL_RST;
      misc_r <= ACF_MISC_RST;
      bias_r <= 16'h0000;
    end
    else if (reg_we)
    begin
      if (reg_addr == ACF_ADDR_CTRL)
        ctrl_r <= reg_wdata[5:0];
      if (reg_addr == ACF_ADDR_MISC)
        misc_r <= reg_wdata[2:0];
      if (reg_addr == ACF_ADDR_BIAS)
        bias_r <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < ACF_NUM_CHAN; i++)
        chan_r[i] <= (i == 0) ? ACF_CHAN0_RST : '0;
      for (int i = 0; i < ACF_NUM_SETUP; i++)
      begin
        cfg_r[i]  <= '0;
        filt_r[i] <= (i == 0) ? ACF_FILT_RST : '0;
      end
    end
    else
    begin
      if (wr_chan)
        chan_r[reg_addr[3:0]] <= reg_wdata[23:0];
      if (wr_cfg)
        cfg_r[reg_addr[2:0]] <= reg_wdata[9:0];
      if (wr_filt)
        filt_r[reg_addr[2:0]] <= reg_wdata[17:0];
    end
  end

  // main clock source
  logic        int_pin_sel;
  logic [1:0]  clk_sel;
  logic        use_ext;
  logic [9:0]  osc_cnt_r;
  logic        osc_lvl_r;
  logic        osc_half;
  logic        sync1_r;
  logic        sync2_r;
  logic        sync3_r;
  logic        ext_lvl_r;
  logic        ext_rise;
  logic        ext_div_r;
  logic        ext_tick;
  logic        int_tick;
  logic        mod_ph_r;

  assign int_pin_sel = ctrl_r[ACF_CTRL_INT_PIN];
  assign clk_sel     = ctrl_r[ACF_CTRL_MCLK_LO +: 2];
  // the pin cannot carry a clock in while it carries the interrupt out
  assign use_ext     = clk_sel[1] && !int_pin_sel;
  assign osc_half    = (osc_cnt_r == 10'(ACF_OSC_HALF_CYC - 1));
  assign int_tick    = osc_half && !osc_lvl_r;
  assign ext_rise    = (sync2_r == sync3_r) && sync3_r && !ext_lvl_r;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_cnt_r <= 10'h000;
      osc_lvl_r <= 1'b0;
    end
    else if (osc_half)
    begin
      osc_cnt_r <= 10'h000;
      osc_lvl_r <= !osc_lvl_r;
    end
    else
      osc_cnt_r <= osc_cnt_r + 10'h001;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_r   <= 1'b0;
      sync2_r   <= 1'b0;
      sync3_r   <= 1'b0;
      ext_lvl_r <= 1'b0;
      ext_div_r <= 1'b0;
    end
    else
    begin
      sync1_r <= clk_pin_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r)
        ext_lvl_r <= sync3_r;
      if (ext_rise)
        ext_div_r <= !ext_div_r;
    end
  end

  always_comb
  begin
    case (clk_sel)
      ACF_CK_EXT:     ext_tick = ext_rise;
      ACF_CK_EXT_DIV: ext_tick = ext_rise && ext_div_r;
      default:        ext_tick = 1'b0;
    endcase
  end

  assign mclk_tick = use_ext ? ext_tick : int_tick;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      mod_ph_r <= 1'b0;
    else if (mclk_tick)
      mod_ph_r <= !mod_ph_r;
  end

  assign mod_tick = mclk_tick && mod_ph_r;

  // conversion sequencer
  acf_state_t  st_r;
  logic [3:0]  cur_r;
  logic [19:0] cnt_r;
  logic [19:0] period_r;
  acf_chan_t   act_chan_r;
  acf_cfg_t    act_cfg_r;
  acf_filt_t   act_filt_r;
  logic        done_r;
  logic [15:0] conv_cnt_r;
  logic        run;
  logic [15:0] en_vec;
  logic [3:0]  nxt_idx;
  acf_chan_t   nxt_chan;
  acf_filt_t   nxt_filt;
  logic        conv_end;

  always_comb
  begin
    for (int i = 0; i < ACF_NUM_CHAN; i++)
      en_vec[i] = chan_r[i].enable;
  end

  assign run      = ctrl_r[ACF_CTRL_RUN] && !standby && (en_vec != 16'h0000);
  assign nxt_idx  = next_chan((st_r == ACF_ST_IDLE) ? 4'hf : cur_r, en_vec);
  assign nxt_chan = chan_r[nxt_idx];
  assign nxt_filt = filt_r[nxt_chan.setup];
  assign conv_end = (st_r == ACF_ST_CONV) && mclk_tick && (cnt_r == 20'd1);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r       <= ACF_ST_IDLE;
      cur_r      <= 4'h0;
      cnt_r      <= 20'd0;
      period_r   <= 20'd0;
      act_chan_r <= '0;
      act_cfg_r  <= '0;
      act_filt_r <= ACF_FILT_RST;
      done_r     <= 1'b0;
      conv_cnt_r <= 16'h0000;
    end
    else
    begin
      done_r <= 1'b0;
      if (!run)
        st_r <= ACF_ST_IDLE;
      else
      begin
        case (st_r)
          ACF_ST_IDLE:
          begin
            // mux and setup are latched only at a conversion boundary
            cur_r      <= nxt_idx;
            act_chan_r <= nxt_chan;
            act_cfg_r  <= cfg_r[nxt_chan.setup];
            act_filt_r <= nxt_filt;
            period_r   <= conv_period(nxt_filt);
            cnt_r      <= ACF_SETTLE_BASE << nxt_filt.front_end_settle_field;
            st_r       <= ACF_ST_SETTLE;
          end
          ACF_ST_SETTLE:
          begin
            if (mclk_tick)
            begin
              if (cnt_r <= 20'd1)
              begin
                cnt_r <= period_r;
                st_r  <= ACF_ST_CONV;
              end
              else
                cnt_r <= cnt_r - 20'd1;
            end
          end
          ACF_ST_CONV:
          begin
            if (conv_end)
            begin
              done_r     <= 1'b1;
              conv_cnt_r <= conv_cnt_r + 16'h0001;
              cur_r      <= nxt_idx;
              act_chan_r <= nxt_chan;
              act_cfg_r  <= cfg_r[nxt_chan.setup];
              act_filt_r <= nxt_filt;
              period_r   <= conv_period(nxt_filt);
              if (nxt_idx != cur_r)
              begin
                cnt_r <= ACF_SETTLE_BASE << nxt_filt.front_end_settle_field;
                st_r  <= ACF_ST_SETTLE;
              end
              else
                cnt_r <= conv_period(nxt_filt);
            end
            else if (mclk_tick)
              cnt_r <= cnt_r - 20'd1;
          end
          default: st_r <= ACF_ST_IDLE;
        endcase
      end
    end
  end

  assign conv_done = done_r;

  // data ready: a new result wins over a status read in the same cycle
  logic dr_r;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      dr_r <= 1'b0;
    else if (done_r)
      dr_r <= 1'b1;
    else if (rd_status)
      dr_r <= 1'b0;
  end
  assign data_ready = dr_r;

  // analog front-end and reference controls
  logic exc_kill;
  assign exc_kill = standby && misc_r[ACF_MISC_EXC_OFF];

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fe      <= '0;
      ref_ctl <= '0;
    end
    else
    begin
      fe.bias_mask              <= bias_r;
      fe.positive_input_select  <= act_chan_r.positive_input_select;
      fe.negative_input_select  <= act_chan_r.negative_input_select;
      fe.excitation_a_pin_route <= act_chan_r.excitation_a_pin_route;
      fe.excitation_b_pin_route <= act_chan_r.excitation_b_pin_route;
      fe.excitation_a_magnitude <= exc_kill ? 3'h0 :
                                   act_cfg_r.excitation_a_magnitude;
      fe.excitation_b_magnitude <= exc_kill ? 3'h0 :
                                   act_cfg_r.excitation_b_magnitude;
      fe.ref_sel                <= act_cfg_r.ref_sel;
      fe.refbuf_en              <= act_cfg_r.refbuf_en;
      ref_ctl.core_on    <= ctrl_r[ACF_CTRL_REF_EN] &&
                            (!standby || misc_r[ACF_MISC_KEEP_ON]);
      ref_ctl.level_1v25 <= ctrl_r[ACF_CTRL_REF_EN] &&
                            ctrl_r[ACF_CTRL_REF_LVL];
      ref_ctl.holder_on  <= ctrl_r[ACF_CTRL_REF_EN] && standby &&
                            misc_r[ACF_MISC_HOLDER];
    end
  end

  // clock pin
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clk_pin_o  <= 1'b0;
      clk_pin_oe <= 1'b0;
    end
    else if (int_pin_sel)
    begin
      clk_pin_o  <= dr_r;
      clk_pin_oe <= 1'b1;
    end
    else
    begin
      clk_pin_o  <= osc_lvl_r;
      clk_pin_oe <= (clk_sel == ACF_CK_INT_OUT);
    end
  end

  // register read, data valid only in the cycle after the strobe
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (reg_addr == ACF_ADDR_CTRL)
      rd_nxt = {26'h0, ctrl_r};
    else if (reg_addr == ACF_ADDR_MISC)
      rd_nxt = {29'h0, misc_r};
    else if (reg_addr == ACF_ADDR_BIAS)
      rd_nxt = {16'h0, bias_r};
    else if (reg_addr == ACF_ADDR_STATUS)
      rd_nxt = {conv_cnt_r, 4'h0, cur_r, 4'h0, st_r, dr_r};
    else if (reg_addr[7:4] == ACF_ADDR_CHAN[7:4])
      rd_nxt = {8'h0, chan_r[reg_addr[3:0]]};
    else if (reg_addr[7:3] == ACF_ADDR_CFG[7:3])
      rd_nxt = {22'h0, cfg_r[reg_addr[2:0]]};
    else if (reg_addr[7:3] == ACF_ADDR_FILT[7:3])
      rd_nxt = {14'h0, filt_r[reg_addr[2:0]]};
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= reg_re ? rd_nxt : 32'h0000_0000;
  end
  assign reg_rdata = rdata_r;

  // checks
  // main ticks since the last modulator tick, saturating
  logic [1:0] mod_gap_r;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      mod_gap_r <= 2'h0;
    else if (mod_tick)
      mod_gap_r <= 2'h0;
    else if (mclk_tick && mod_gap_r != 2'h3)
      mod_gap_r <= mod_gap_r + 2'h1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_sinc4_period: assert property (
    (st_r == ACF_ST_CONV && act_filt_r.ftype == ACF_F_SINC4)
      |-> period_r == 20'(act_filt_r.rate_divider) * 20'd32 ||
          act_filt_r.rate_divider == 11'h000)
    else $error("sinc4 period wrong");
  a_sinc4_avg: assert property (
    (st_r == ACF_ST_CONV && act_filt_r.ftype == ACF_F_SINC4_AVG &&
     act_filt_r.rate_divider != 11'h000)
      |-> period_r == 20'(act_filt_r.rate_divider) * 20'd352)
    else $error("sinc4 averaging period wrong");
  a_sinc3_period: assert property (
    (st_r == ACF_ST_CONV && act_filt_r.ftype == ACF_F_SINC3_REJ &&
     act_filt_r.rate_divider == 11'd48) |-> period_r == 20'd1536)
    else $error("notch period wrong");
  a_sinc3_avg: assert property (
    (st_r == ACF_ST_CONV && act_filt_r.ftype == ACF_F_SINC3_AVG &&
     act_filt_r.rate_divider != 11'h000)
      |-> period_r == 20'(act_filt_r.rate_divider) * 20'd320)
    else $error("sinc3 averaging period wrong");
  a_post_fixed: assert property (
    (st_r == ACF_ST_CONV && act_filt_r.ftype == ACF_F_SINC3_PF)
      |-> period_r inside {20'd4738, 20'd3968, 20'd3200, 20'd2944})
    else $error("post filter rate not fixed");
  a_mod_half: assert property (
    mclk_tick |-> mod_tick == (mod_gap_r == 2'h1))
    else $error("modulator tick not every second tick");
  a_pin_prio: assert property (
    $past(int_pin_sel) |-> clk_pin_oe && clk_pin_o == $past(dr_r))
    else $error("interrupt lost clock pin");
  a_ref_off: assert property (
    !$past(ctrl_r[ACF_CTRL_REF_EN]) |-> !ref_ctl.core_on &&
      !ref_ctl.level_1v25)
    else $error("reference on while disabled");
  a_mux_stable: assert property (
    (st_r == ACF_ST_CONV && !conv_end) |=> $stable(act_chan_r))
    else $error("mux changed mid conversion");
  a_exc_standby: assert property (
    $past(exc_kill) |-> fe.excitation_a_magnitude == 3'h0 &&
      fe.excitation_b_magnitude == 3'h0)
    else $error("excitation on in standby");

  c_conv_done: cover property (conv_done);
  c_ext_clock: cover property (use_ext && mclk_tick);
  c_switch: cover property (conv_end ##1 st_r == ACF_ST_SETTLE);
  c_post: cover property (conv_done && act_filt_r.ftype == ACF_F_SINC3_PF);

endmodule : acf_ctrl
`default_nettype wire

//--- shared/acf_pkg.sv
// constants, field layouts and carrier types for the converter setup control
package acf_pkg;

  localparam int unsigned ACF_NUM_CHAN  = 16;
  localparam int unsigned ACF_NUM_SETUP = 8;

  // register word addresses
  localparam logic [7:0] ACF_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ACF_ADDR_MISC   = 8'h01;
  localparam logic [7:0] ACF_ADDR_BIAS   = 8'h02;
  localparam logic [7:0] ACF_ADDR_STATUS = 8'h03;
  localparam logic [7:0] ACF_ADDR_CHAN   = 8'h10;
  localparam logic [7:0] ACF_ADDR_CFG    = 8'h20;
  localparam logic [7:0] ACF_ADDR_FILT   = 8'h28;

  // control register bits
  localparam int unsigned ACF_CTRL_REF_EN  = 0;
  localparam int unsigned ACF_CTRL_REF_LVL = 1;
  localparam int unsigned ACF_CTRL_MCLK_LO = 2;
  localparam int unsigned ACF_CTRL_INT_PIN = 4;
  localparam int unsigned ACF_CTRL_RUN     = 5;
  localparam logic [5:0]  ACF_CTRL_RST     = 6'h00;

  // misc register bits
  localparam int unsigned ACF_MISC_HOLDER  = 0;
  localparam int unsigned ACF_MISC_KEEP_ON = 1;
  localparam int unsigned ACF_MISC_EXC_OFF = 2;
  localparam logic [2:0]  ACF_MISC_RST     = 3'h0;

  // timing
  localparam int unsigned ACF_SYS_HZ       = 100_000_000;
  localparam int unsigned ACF_MCLK_HZ      = 76_800;
  localparam int unsigned ACF_OSC_HALF_CYC = ACF_SYS_HZ / (2 * ACF_MCLK_HZ);
  localparam int unsigned ACF_AVG          = 8;
  localparam logic [19:0] ACF_TICKS_PER_FS = 20'd32;
  localparam logic [19:0] ACF_SINC4_AVG    = 20'(32 * (4 + ACF_AVG - 1));
  localparam logic [19:0] ACF_SINC3_AVG    = 20'(32 * (3 + ACF_AVG - 1));
  // fixed post-filter periods in main clock ticks, for output rates of 16.21, 19.355, 24, 26.087 Hz
  localparam logic [19:0] ACF_POST_P0      = 20'd4738;
  localparam logic [19:0] ACF_POST_P1      = 20'd3968;
  localparam logic [19:0] ACF_POST_P2      = 20'd3200;
  localparam logic [19:0] ACF_POST_P3      = 20'd2944;
  localparam logic [19:0] ACF_SETTLE_BASE  = 20'd16;

  // divider limits
  localparam logic [10:0] ACF_FS_MAX_SINC4 = 11'h00a;
  localparam logic [10:0] ACF_FS_MAX_SINC3 = 11'h7ff;
  localparam logic [10:0] ACF_FS_REC_AVG3  = 11'h0cc;
  localparam logic [10:0] ACF_FS_NOTCH     = 11'd48;
  localparam logic [10:0] ACF_FS_RST       = 11'h030;

  typedef enum logic [2:0] {
    ACF_F_SINC4     = 3'h0,
    ACF_F_SINC4_AVG = 3'h1,
    ACF_F_SINC3     = 3'h2,
    ACF_F_SINC3_REJ = 3'h3,
    ACF_F_SINC3_AVG = 3'h4,
    ACF_F_SINC3_PF  = 3'h5
  } acf_filter_t;

  typedef enum logic [1:0] {
    ACF_CK_INT     = 2'h0,
    ACF_CK_INT_OUT = 2'h1,
    ACF_CK_EXT     = 2'h2,
    ACF_CK_EXT_DIV = 2'h3
  } acf_clk_sel_t;

  typedef struct packed {
    logic [4:0] excitation_b_pin_route;
    logic [4:0] excitation_a_pin_route;
    logic [4:0] negative_input_select;
    logic [4:0] positive_input_select;
    logic [2:0] setup;
    logic       enable;
  } acf_chan_t;

  typedef struct packed {
    logic [2:0] excitation_b_magnitude;
    logic [2:0] excitation_a_magnitude;
    logic [1:0] refbuf_en;
    logic [1:0] ref_sel;
  } acf_cfg_t;

  typedef struct packed {
    logic [1:0]  post_sel;
    logic [1:0]  front_end_settle_field;
    acf_filter_t ftype;
    logic [10:0] rate_divider;
  } acf_filt_t;

  typedef struct packed {
    logic [15:0] bias_mask;
    logic [4:0]  positive_input_select;
    logic [4:0]  negative_input_select;
    logic [2:0]  excitation_a_magnitude;
    logic [4:0]  excitation_a_pin_route;
    logic [2:0]  excitation_b_magnitude;
    logic [4:0]  excitation_b_pin_route;
    logic [1:0]  ref_sel;
    logic [1:0]  refbuf_en;
  } acf_fe_t;

  typedef struct packed {
    logic core_on;
    logic level_1v25;
    logic holder_on;
  } acf_ref_t;

  localparam acf_chan_t ACF_CHAN0_RST = '{
    excitation_b_pin_route: 5'h00, excitation_a_pin_route: 5'h00,
    negative_input_select: 5'h01, positive_input_select: 5'h00,
    setup: 3'h0, enable: 1'b1};
  localparam acf_filt_t ACF_FILT_RST = '{
    post_sel: 2'h0, front_end_settle_field: 2'h0,
    ftype: ACF_F_SINC3, rate_divider: ACF_FS_RST};

endpackage : acf_pkg

//--- test/acf_ext_clk_src.sv
// behavioural external main clock source driving the clock pin
`timescale 1ns/1ps
`default_nettype none
module acf_ext_clk_src (
  input  wire logic en,
  input  wire logic fast,
  output logic      clk_out
);
  initial clk_out = 1'b0;
  // 76.8 kHz square; parks low while disabled so no stale edge leaks out
  // fast mode ticks every 80 ns so the long filters fit in the run
  always
  begin
    if (fast)
      #40;
    else
      #6510;
    clk_out = en ? ~clk_out : 1'b0;
  end
endmodule : acf_ext_clk_src
`default_nettype wire

//--- test/test_acf_ctrl.sv
// self-checking bench for the converter setup control
`timescale 1ns/1ps
`default_nettype none
module test_acf_ctrl
  import acf_pkg::*;
;
  logic        mclk, arst_n, reg_we, reg_re, standby, ext_en, ext_clk;
  logic        clk_pin_o, clk_pin_oe, mclk_tick, mod_tick, conv_done;
  logic        data_ready, pin, ext_fast;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  acf_fe_t     fe;
  acf_ref_t    ref_ctl;
  int          n_fail, check_count, nt, nm, cyc;

  // the block's own drive wins over the external source on the pin
  assign pin = clk_pin_oe ? clk_pin_o : ext_clk;

  acf_ctrl acf_ctrl_i (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .standby(standby), .clk_pin_i(pin),
    .clk_pin_o(clk_pin_o), .clk_pin_oe(clk_pin_oe),
    .mclk_tick(mclk_tick), .mod_tick(mod_tick), .conv_done(conv_done),
    .data_ready(data_ready), .fe(fe), .ref_ctl(ref_ctl));

  acf_ext_clk_src acf_ext_clk_src_i (.en(ext_en), .fast(ext_fast),
    .clk_out(ext_clk));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string s, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, exp, got);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic count_ticks(input int n);
    nt = 0;
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      nt += int'(mclk_tick === 1'b1);
    end
  endtask : count_ticks

  // counts main ticks up to and including the next conversion end
  task automatic wait_done(input int lim);
    nt  = 0;
    cyc = 0;
    do
    begin
      @(posedge mclk);
      #1;
      nt += int'(mclk_tick === 1'b1);
      cyc++;
    end
    while (cyc < lim && conv_done !== 1'b1);
  endtask : wait_done

  task automatic t_reset;
    rd(ACF_ADDR_CTRL, v);
    chk("ctrl", 32'h0, v);
    rd(ACF_ADDR_CHAN, v);
    chk("chan0", 32'h201, v);
    rd(ACF_ADDR_FILT, v);
    chk("filt0", 32'h1030, v);
    rd(8'hff, v);
    chk("unmapped", 32'h0, v);
    chk("ref", 32'h0, ref_ctl);
    chk("pin oe", 32'h0, clk_pin_oe);
  endtask : t_reset

  task automatic t_ref;
    wr(ACF_ADDR_CTRL, 32'h2);
    wt(3);
    chk("level off", 1'b0, ref_ctl.level_1v25);
    chk("core off", 1'b0, ref_ctl.core_on);
    wr(ACF_ADDR_CTRL, 32'h3);
    wt(3);
    chk("level", 1'b1, ref_ctl.level_1v25);
    chk("core on", 1'b1, ref_ctl.core_on);
  endtask : t_ref

  task automatic t_conv;
    wr(ACF_ADDR_CHAN, 32'h39c831);
    wr(ACF_ADDR_CFG, 32'hfe);
    wr(ACF_ADDR_BIAS, 32'h8001);
    wr(ACF_ADDR_FILT, 32'h1);
    wr(ACF_ADDR_CTRL, 32'h23);
    wt(20);
    chk("pos", 5'h03, fe.positive_input_select);
    chk("neg", 5'h04, fe.negative_input_select);
    v = {fe.excitation_a_pin_route, fe.excitation_b_pin_route};
    chk("routes", 10'h0e7, v);
    v = {fe.excitation_a_magnitude, fe.excitation_b_magnitude};
    chk("mags", 6'h39, v);
    chk("ref sel", 2'h2, fe.ref_sel);
    chk("buf", 2'h3, fe.refbuf_en);
    chk("bias", 16'h8001, fe.bias_mask);
    wr(ACF_ADDR_CHAN, 32'h39c891);
    wt(5);
    chk("pos held", 5'h03, fe.positive_input_select);
    nt = 0;
    nm = 0;
    for (cyc = 0; cyc < 70000 && conv_done !== 1'b1; cyc++)
    begin
      @(posedge mclk);
      #1;
      nt += int'(mclk_tick === 1'b1);
      nm += int'(mod_tick === 1'b1);
    end
    chk("done", 1'b1, conv_done);
    chk("ticks", 1'b1, nt >= 47 && nt <= 49);
    chk("mod", 1'b1, nm * 2 >= nt - 1 && nm * 2 <= nt + 1);
    wt(3);
    chk("pos new", 5'h09, fe.positive_input_select);
    chk("ready", 1'b1, data_ready);
    rd(ACF_ADDR_STATUS, v);
    chk("status", 1'b1, v[0]);
    rd(ACF_ADDR_STATUS, v);
    chk("status clr", 1'b0, v[0]);
  endtask : t_conv

  task automatic t_standby;
    wr(ACF_ADDR_MISC, 32'h7);
    @(posedge mclk);
    standby <= 1'b1;
    wt(4);
    v = {fe.excitation_a_magnitude, fe.excitation_b_magnitude};
    chk("exc off", 6'h0, v);
    chk("keep on", 1'b1, ref_ctl.core_on);
    chk("holder", 1'b1, ref_ctl.holder_on);
    wr(ACF_ADDR_MISC, 32'h4);
    wt(3);
    chk("core standby", 1'b0, ref_ctl.core_on);
    chk("holder off", 1'b0, ref_ctl.holder_on);
    chk("exc still off", 6'h0, {fe.excitation_a_magnitude,
                                fe.excitation_b_magnitude});
    @(posedge mclk);
    standby <= 1'b0;
  endtask : t_standby

  task automatic t_pin;
    wr(ACF_ADDR_CTRL, 32'h4);
    wt(3);
    chk("int out", 1'b1, clk_pin_oe);
    wr(ACF_ADDR_CTRL, 32'h14);
    wt(3);
    chk("int pin", 2'b10, {clk_pin_oe, clk_pin_o});
    @(posedge mclk);
    ext_en <= 1'b1;
    wr(ACF_ADDR_CTRL, 32'h8);
    count_ticks(6000);
    chk("ext oe", 1'b0, clk_pin_oe);
    chk("ext ticks", 1'b1, nt >= 4 && nt <= 5);
    wr(ACF_ADDR_CTRL, 32'hc);
    count_ticks(6000);
    chk("div ticks", 1'b1, nt >= 2 && nt <= 3);
  endtask : t_pin

  // two channels alternate between the two averaging filters
  task automatic t_filt;
    wr(ACF_ADDR_FILT + 8'h1, 32'h0801);
    wr(ACF_ADDR_FILT + 8'h2, 32'h2001);
    wr(ACF_ADDR_CHAN, 32'h3);
    wr(ACF_ADDR_CHAN + 8'h1, 32'h5);
    @(posedge mclk);
    ext_fast <= 1'b1;
    wr(ACF_ADDR_CTRL, 32'h28);
    wait_done(8000);
    chk("first done", 1'b1, conv_done);
    wait_done(8000);
    chk("sinc3 avg", ACF_SETTLE_BASE + ACF_SINC3_AVG, nt);
    wait_done(8000);
    chk("sinc4 avg", ACF_SETTLE_BASE + ACF_SINC4_AVG, nt);
  endtask : t_filt

  // full sequence takes about 83k cycles; a hang stops at 95k
  initial
  begin
    #950_000;
    n_fail++;
    stop_test;
  end

  initial
  begin
    {reg_we, reg_re, standby, ext_en, ext_fast} = 5'h00;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0;
    arst_n      = 1'b0;
    n_fail      = 0;
    check_count = 0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset;
    t_ref;
    t_conv;
    t_standby;
    t_pin;
    t_filt;
    stop_test;
  end
endmodule : test_acf_ctrl
`default_nettype wire
